// ---- include/adsq_defines.svh ----
// Register offsets, field positions and timing constants of the converter
`ifndef ADSQ_DEFINES_SVH
`define ADSQ_DEFINES_SVH
`define ADSQ_ADDR_W 8
`define ADSQ_OFF_CTRL_LOW 8'h9C
`define ADSQ_OFF_CTRL_HIGH 8'h9D
`define ADSQ_OFF_RESULT_LOW 8'h9E
`define ADSQ_OFF_RESULT_HIGH 8'h9F
`define ADSQ_OFF_IRQ_STATUS 8'hA0
`define ADSQ_OFF_IRQ_ENABLE 8'hA1
`define ADSQ_OFF_IRQ_CLEAR 8'hA2
`define ADSQ_CTRL_LOW_RESET 8'h00
`define ADSQ_CTRL_HIGH_RESET 8'h00
`define ADSQ_BIT_ENABLE 7
`define ADSQ_BIT_START 6
`define ADSQ_BIT_REFERENCE_SOURCE_SELECT 5
`define ADSQ_BIT_DONE 4
`define ADSQ_BIT_IRQ_FLAG 7
`define ADSQ_BIT_ALIGN 2
`define ADSQ_FLD_CHAN 3:0
`define ADSQ_FLD_START_SOURCE_SELECT 5:3
`define ADSQ_FLD_CLKSEL 1:0
`define ADSQ_SETUP_CYCLES 4'hA
`define ADSQ_STEPS_PER_BIT 2'h3
`define ADSQ_RESULT_BITS 4'hC
`define ADSQ_DIV_W 3
`define ADSQ_MIN_CONV_NS 20000
`define ADSQ_CLK_PERIOD_NS 8
`define ADSQ_MIN_CONV_CYCLES (`ADSQ_MIN_CONV_NS / `ADSQ_CLK_PERIOD_NS)
`endif

// ---- include/adsq_pkg.sv ----
// Types of the converter sequencer
package adsq_pkg;
   typedef enum logic [2:0]
   {
      ADSQ_START_SOURCE_SELECT_SOFT,
      ADSQ_START_SOURCE_SELECT_T1A,
      ADSQ_START_SOURCE_SELECT_T4OVF,
      ADSQ_START_SOURCE_SELECT_T4A,
      ADSQ_START_SOURCE_SELECT_T4B,
      ADSQ_START_SOURCE_SELECT_T4C,
      ADSQ_START_SOURCE_SELECT_NONE6,
      ADSQ_START_SOURCE_SELECT_NONE7
   } adsq_start_source_select_t;
   typedef enum logic [1:0]
   {
      ADSQ_IDLE,
      ADSQ_SETUP,
      ADSQ_BITS
   } adsq_state_t;
endpackage

// ---- hdl/adsq_clkdiv.sv ----
// Conversion clock tick generator
`timescale 1ns/1ps
`include "adsq_defines.svh"
module adsq_clkdiv
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   input wire logic [1:0] sel,
   output logic tick
);
   logic [`ADSQ_DIV_W-1:0] cnt;
   logic [`ADSQ_DIV_W-1:0] lim;

   // Divide by 1, 2, 4 or 8 [RQ8]
   assign lim = 3'((4'h1 << sel) - 4'h1);
   assign tick = run && (cnt == lim);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt <= 3'h0;
      else if (ce)
      begin
         if (!run || tick)
            cnt <= 3'h0;
         else
            cnt <= 3'(cnt + 3'h1);
      end
   end
endmodule

// ---- hdl/adsq_start_source_select_sync.sv ----
// Trigger source synchroniser and rising-edge detector
`timescale 1ns/1ps
module adsq_start_source_select_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [4:0] start_source_select_in,
   output logic [4:0] start_source_select_pulse
);
   logic [4:0] s1;
   logic [4:0] s2;
   logic [4:0] s3;

   genvar i;
   generate
      for (i = 0; i < 5; i++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               s1[i] <= 1'b0;
               s2[i] <= 1'b0;
               s3[i] <= 1'b0;
            end
            else if (ce)
            begin
               s1[i] <= start_source_select_in[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
            end
         end
         assign start_source_select_pulse[i] = ce && s2[i] && !s3[i];
      end
   endgenerate
endmodule

// ---- hdl/adsq_top.sv ----
// Converter sequencer: registers, sequencing, result alignment, interrupt
// Notes on behaviour
// RQ1: Four-bit channel field routes analog input n to the converter.
// RQ2: At end, load result, set done flag, raise interrupt request.
// RQ3: Done flag reads zero while a conversion runs.
// RQ4: Ten setup clocks, then four conversion clocks per each of twelve bits.
// RQ5: Software picks a divider so conversion lasts at least 20 us.
// RQ6: Three-bit field picks start source: soft, timer 1 A, timer 4 events.
// RQ7: Alignment bit places the result msb-aligned or lsb-aligned.
// RQ8: Clock field divides system clock by 1, 2, 4 or 8.
// RQ9: Interrupt flag set on event, cleared by writing zero or acknowledge.
// RQ10: Enable bit powers the converter; stop mode forces it off.
// RQ11: Writing one to start bit begins conversion; bit self-clears.
// RQ12: Reference bit picks supply at zero, external pin at one.
// RQ13: Done flag clears when disabled or in stop mode.
// RQ14: Selected hardware trigger starts conversion only while enabled.
`timescale 1ns/1ps
`include "adsq_defines.svh"
module adsq_top
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic stop_mode,
   input wire logic irq_ack,
   input wire logic timer1_a_match,
   input wire logic timer4_overflow,
   input wire logic timer4_a_match,
   input wire logic timer4_b_match,
   input wire logic timer4_c_match,
   input wire logic [11:0] sar_result,
   output logic [3:0] input_channel_select,
   output logic reference_source_select,
   output logic module_power_enable,
   output logic sar_sample,
   output logic sar_step,
   output logic conv_irq,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_low;
   logic [7:0] ctrl_high;
   logic [7:0] result_low;
   logic [7:0] result_high;
   logic software_start_bit;
   logic conversion_done_flag;
   logic conv_irq_flag;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   adsq_pkg::adsq_state_t state;
   logic [3:0] step_cnt;
   logic [3:0] bit_cnt;
   logic tick;
   logic running;
   logic enabled;
   logic start_req;
   logic hw_start;
   logic conv_end;
   logic [4:0] start_source_select_pulse;
   logic [11:0] res;
   logic wr_low;
   logic wr_high;
   adsq_pkg::adsq_start_source_select_t start_source_select;

   assign wr_low = ce && wr && (addr == `ADSQ_OFF_CTRL_LOW);
   assign wr_high = ce && wr && (addr == `ADSQ_OFF_CTRL_HIGH);
   // Stop mode overrides the enable bit [RQ10]
   assign enabled = ctrl_low[`ADSQ_BIT_ENABLE] && !stop_mode;
   assign module_power_enable = enabled; // [RQ10]
   assign reference_source_select = ctrl_low[`ADSQ_BIT_REFERENCE_SOURCE_SELECT]; // [RQ12]
   assign input_channel_select = ctrl_low[`ADSQ_FLD_CHAN]; // [RQ1]
   assign start_source_select =
      adsq_pkg::adsq_start_source_select_t'(ctrl_high[`ADSQ_FLD_START_SOURCE_SELECT]); // [RQ6]
   assign running = (state != adsq_pkg::ADSQ_IDLE);

   ////////////////////////////////////////////////////////////////////////
   adsq_start_source_select_sync u_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .start_source_select_in({timer4_c_match, timer4_b_match, timer4_a_match,
                timer4_overflow, timer1_a_match}),
      .start_source_select_pulse(start_source_select_pulse)
   );

   adsq_clkdiv u_div
   (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(running),
      .sel(ctrl_high[`ADSQ_FLD_CLKSEL]),
      .tick(tick)
   );

   // Unused trigger codes never start anything [RQ6]
   always_comb
   begin
      case (start_source_select)
         adsq_pkg::ADSQ_START_SOURCE_SELECT_T1A: hw_start = start_source_select_pulse[0];
         adsq_pkg::ADSQ_START_SOURCE_SELECT_T4OVF: hw_start = start_source_select_pulse[1];
         adsq_pkg::ADSQ_START_SOURCE_SELECT_T4A: hw_start = start_source_select_pulse[2];
         adsq_pkg::ADSQ_START_SOURCE_SELECT_T4B: hw_start = start_source_select_pulse[3];
         adsq_pkg::ADSQ_START_SOURCE_SELECT_T4C: hw_start = start_source_select_pulse[4];
         default: hw_start = 1'b0;
      endcase
   end

   // Hardware and software start only while enabled [RQ14] [RQ11]
   // Start bit counts only while the software source is picked [RQ6]
   assign start_req = enabled && !running
      && ((software_start_bit
         && (start_source_select == adsq_pkg::ADSQ_START_SOURCE_SELECT_SOFT)) || hw_start);

   ////////////////////////////////////////////////////////////////////////
   // Control registers; done flag is held separately
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl_low <= `ADSQ_CTRL_LOW_RESET;
         ctrl_high <= `ADSQ_CTRL_HIGH_RESET;
      end
      else if (wr_low)
         ctrl_low <= wdata;
      else if (wr_high)
         ctrl_high <= wdata;
   end

   // Start bit: write one sets, taken start clears; zero write no effect
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         software_start_bit <= 1'b0;
      else if (ce)
      begin
         // Written enable counts, so enable and start may share a write
         if (wr_low && wdata[`ADSQ_BIT_START] && wdata[`ADSQ_BIT_ENABLE]
            && !stop_mode)
            software_start_bit <= 1'b1; // [RQ11]
         else if (!enabled || running
            || (start_source_select != adsq_pkg::ADSQ_START_SOURCE_SELECT_SOFT))
            software_start_bit <= 1'b0; // [RQ11] [RQ10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: ten setup ticks, then four per bit for twelve bits
   assign conv_end = (state == adsq_pkg::ADSQ_BITS) && tick
      && (step_cnt == 4'(`ADSQ_STEPS_PER_BIT))
      && (bit_cnt == 4'(`ADSQ_RESULT_BITS - 4'h1));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= adsq_pkg::ADSQ_IDLE;
         step_cnt <= 4'h0;
         bit_cnt <= 4'h0;
      end
      else if (ce)
      begin
         if (!enabled)
            state <= adsq_pkg::ADSQ_IDLE;
         else
         begin
            case (state)
               adsq_pkg::ADSQ_IDLE:
               begin
                  step_cnt <= 4'h0;
                  bit_cnt <= 4'h0;
                  if (start_req)
                     state <= adsq_pkg::ADSQ_SETUP;
               end
               adsq_pkg::ADSQ_SETUP:
                  if (tick)
                  begin
                     if (step_cnt == `ADSQ_SETUP_CYCLES - 4'h1) // [RQ4]
                     begin
                        step_cnt <= 4'h0;
                        state <= adsq_pkg::ADSQ_BITS;
                     end
                     else
                        step_cnt <= 4'(step_cnt + 4'h1);
                  end
               adsq_pkg::ADSQ_BITS:
                  if (tick)
                  begin
                     if (conv_end)
                        state <= adsq_pkg::ADSQ_IDLE; // [RQ4]
                     else if (step_cnt == 4'(`ADSQ_STEPS_PER_BIT))
                     begin
                        step_cnt <= 4'h0;
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                     end
                     else
                        step_cnt <= 4'(step_cnt + 4'h1);
                  end
               default:
                  state <= adsq_pkg::ADSQ_IDLE;
            endcase
         end
      end
   end

   assign sar_sample = (state == adsq_pkg::ADSQ_SETUP);
   assign sar_step = (state == adsq_pkg::ADSQ_BITS) && tick;

   ////////////////////////////////////////////////////////////////////////
   // Result alignment [RQ7]
   assign res = sar_result;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         result_low <= 8'h00;
         result_high <= 8'h00;
      end
      else if (ce && conv_end)
      begin
         if (ctrl_high[`ADSQ_BIT_ALIGN])
         begin
            result_high <= {4'h0, res[11:8]}; // [RQ7]
            result_low <= res[7:0];
         end
         else
         begin
            result_high <= res[11:4]; // [RQ7] [RQ2]
            result_low <= {res[3:0], 4'h0};
         end
      end
   end

   // Done flag: zero while running, disabled or stopped [RQ3] [RQ13]
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         conversion_done_flag <= 1'b0;
      else if (ce)
      begin
         if (!enabled || start_req)
            conversion_done_flag <= 1'b0; // [RQ13] [RQ3]
         else if (conv_end)
            conversion_done_flag <= 1'b1; // [RQ2]
      end
   end

   // Interrupt flag: set beats clear [RQ9]
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         conv_irq_flag <= 1'b0;
      else if (ce)
      begin
         if (conv_end)
            conv_irq_flag <= 1'b1; // [RQ2] [RQ9]
         else if (irq_ack || (wr_high && !wdata[`ADSQ_BIT_IRQ_FLAG]))
            conv_irq_flag <= 1'b0; // [RQ9]
      end
   end
   assign conv_irq = conv_irq_flag;

   ////////////////////////////////////////////////////////////////////////
   // Sticky status: bit0 conversion end, bit1 start while busy lost
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_status <= 2'h0;
         irq_enable <= 2'h0;
      end
      else if (ce)
      begin
         if (wr && addr == `ADSQ_OFF_IRQ_ENABLE)
            irq_enable <= wdata[1:0];
         irq_status <= (irq_status
            & ~((wr && addr == `ADSQ_OFF_IRQ_CLEAR) ? wdata[1:0] : 2'h0))
            | {running && (hw_start || (wr_low && wdata[`ADSQ_BIT_START])),
               conv_end};
      end
   end
   assign irq = |(irq_status & irq_enable);

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (ce && rd)
      begin
         case (addr)
            `ADSQ_OFF_CTRL_LOW: rdata <= {ctrl_low[`ADSQ_BIT_ENABLE],
               software_start_bit, ctrl_low[`ADSQ_BIT_REFERENCE_SOURCE_SELECT],
               conversion_done_flag, ctrl_low[`ADSQ_FLD_CHAN]};
            `ADSQ_OFF_CTRL_HIGH: rdata <= {conv_irq_flag, 1'b0,
               ctrl_high[5:0]};
            `ADSQ_OFF_RESULT_LOW: rdata <= result_low;
            `ADSQ_OFF_RESULT_HIGH: rdata <= result_high;
            `ADSQ_OFF_IRQ_STATUS: rdata <= {6'h00, irq_status};
            `ADSQ_OFF_IRQ_ENABLE: rdata <= {6'h00, irq_enable};
            default: rdata <= 8'h00;
         endcase
      end
   end
endmodule

// ---- test/adsq_top_props.sv ----
// Port checker of the converter sequencer
`timescale 1ns/1ps
module adsq_top_props
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic stop_mode,
   input wire logic irq_ack,
   input wire logic [3:0] input_channel_select,
   input wire logic reference_source_select,
   input wire logic module_power_enable,
   input wire logic sar_sample,
   input wire logic sar_step,
   input wire logic conv_irq
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_n);
////////////////////////////////////////
property p_chan;
   wr && ce && addr == 8'h9C |=> input_channel_select == $past(wdata[3:0]);
endproperty
a_chan: assert property (p_chan) else $error("chan");
property p_ref;
   wr && ce && addr == 8'h9C |=> reference_source_select == $past(wdata[5]);
endproperty
a_ref: assert property (p_ref) else $error("ref");
property p_stop;
   stop_mode && $past(stop_mode) |-> !module_power_enable;
endproperty
a_stop: assert property (p_stop) else $error("stop");
// One enabled-off edge is enough to park the sequencer
property p_idle;
   (!module_power_enable && ce) ##1 !module_power_enable
      |-> !sar_sample && !sar_step;
endproperty
a_idle: assert property (p_idle) else $error("idle");
// A step may be the last one, and then the set wins
property p_clr;
   wr && ce && addr == 8'h9D && !wdata[7] && !sar_step |=> !conv_irq;
endproperty
a_clr: assert property (p_clr) else $error("clr");
property p_ack;
   irq_ack && ce && !sar_step |=> !conv_irq;
endproperty
a_ack: assert property (p_ack) else $error("ack");
property p_flag;
   rd && ce && addr == 8'h9D |=> rdata[7] == $past(conv_irq);
endproperty
a_flag: assert property (p_flag) else $error("flag");
property p_busy;
   rd && ce && addr == 8'h9C && (sar_sample || sar_step) |=> !rdata[4];
endproperty
a_busy: assert property (p_busy) else $error("busy");
// The flag is already clear one edge after the enable drops
property p_off;
   (!module_power_enable && ce) ##1 (rd && ce && addr == 8'h9C)
      |=> !rdata[4];
endproperty
a_off: assert property (p_off) else $error("off");
// Setup phase: at least ten system clocks before the first step
logic [11:0] setup_len;
always_ff @(posedge clk)
begin
   if (!sar_sample)
      setup_len <= 12'h000;
   else
      setup_len <= 12'(setup_len + 12'h001);
end
property p_step;
   $fell(sar_sample) && $past(module_power_enable) |-> setup_len >= 12'h00A;
endproperty
a_step: assert property (p_step) else $error("step");
c_step: cover property (sar_step);
c_irq: cover property ($rose(conv_irq));
c_off: cover property (rd && !module_power_enable);
endmodule

// ---- test/adsq_sar_model.sv ----
// Converter far side: result settles only after the bit steps
`timescale 1ns/1ps
module adsq_sar_model
(
   input wire logic clk,
   input wire logic sar_sample,
   input wire logic sar_step,
   input wire logic [3:0] chan,
   input wire logic [11:0] level,
   output logic [11:0] sar_result
);
int steps = 0;
always @(posedge clk)
begin
   if (sar_sample)
      steps <= 0;
   else if (sar_step)
      steps <= steps + 1;
end
// Unresolved bits wander, so an early load shows up
assign sar_result = steps >= 47 ? level + 12'(chan) : ~level ^ 12'(steps);
endmodule

// ---- test/tb_adsq_top.sv ----
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module tb_adsq_top;
logic clk = 0, rst_n = 0, wr = 0, rd = 0, stop_mode = 0, irq_ack = 0, ce = 1;
logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
logic [4:0] tmr = 5'h00;
logic [11:0] lvl = 12'h000, sar_result, r;
logic [3:0] chan = 4'h0, ics;
logic ref_sel, pwr, smp, stp, cirq, irq;
int miscompares = 0, samples_checked = 0, seed = 32'hA112;
int cyc = 0, nstep = 0, t0, n, e;
int exp_q[$];
always #4 clk = ~clk;
always @(posedge clk)
begin
   cyc <= cyc + 1;
   nstep <= smp ? 0 : nstep + int'(stp);
end
adsq_sar_model far (.clk(clk), .sar_sample(smp), .sar_step(stp),
   .chan(ics), .level(lvl), .sar_result(sar_result));
adsq_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode),
   .irq_ack(irq_ack), .timer1_a_match(tmr[0]), .timer4_overflow(tmr[1]),
   .timer4_a_match(tmr[2]), .timer4_b_match(tmr[3]),
   .timer4_c_match(tmr[4]), .sar_result(sar_result),
   .input_channel_select(ics), .reference_source_select(ref_sel),
   .module_power_enable(pwr), .sar_sample(smp), .sar_step(stp),
   .conv_irq(cirq), .irq(irq));
////////////////////////////////////////
task automatic finish_test();
   $display("checks %0d mismatches %0d", samples_checked, miscompares);
   if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
   else
      $display("DONE - FAIL");
   $finish;
endtask
task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
   samples_checked++;
   if (ex !== got)
   begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
   end
endtask
task automatic wreg(logic [7:0] a, logic [7:0] d);
   @(posedge clk);
   addr <= a;
   wdata <= d;
   wr <= 1'b1;
   @(posedge clk);
   wr <= 1'b0;
endtask
task automatic rchk(string nm, logic [7:0] a, logic [7:0] ex);
   @(posedge clk);
   addr <= a;
   rd <= 1'b1;
   @(posedge clk);
   rd <= 1'b0;
   #1 chk(nm, 16'(ex), 16'(rdata));
endtask
task automatic ack();
   @(posedge clk);
   irq_ack <= 1'b1;
   @(posedge clk);
   irq_ack <= 1'b0;
endtask
// Bounded; a missed start ends the run
task automatic wait_irq(logic ex);
   for (n = 0; n < 600 && cirq !== 1'b1; n++)
      @(posedge clk);
   chk("start", 16'(ex), 16'(n < 600));
   if (ex && n == 600)
      finish_test();
endtask
initial
begin
   repeat (20) @(posedge clk);
   rst_n <= 1'b1;
   rchk("ctl_lo", 8'h9C, 8'h00);
   rchk("ctl_hi", 8'h9D, 8'h00);
   rchk("unmapped", 8'hB0, 8'h00);
   for (int s = 0; s < 4; s++)
   begin
      chan = 4'($random(seed));
      lvl = 12'($random(seed));
      exp_q.push_back(int'(lvl) + int'(chan));
      wreg(8'hA1, {7'h00, s != 0});
      wreg(8'h9D, {5'h00, s[0], s[1:0]});
      wreg(8'h9C, {2'h3, s[0], 1'b0, chan});
      t0 = cyc;
      @(posedge clk);
      rchk("busy", 8'h9C, {2'h2, s[0], 1'b0, chan});
      chk("ref", 16'(s[0]), 16'(ref_sel));
      chk("chan", 16'(chan), 16'(ics));
      wait_irq(1'b1);
      // Short dividers keep the run brief; 20 us is software's duty
      e = 58 << s;
      chk("time", 16'h1, 16'(cyc - t0 >= e && cyc - t0 <= e + e / 8 + 6));
      chk("steps", 16'h0030, 16'(nstep));
      r = 12'(exp_q.pop_front());
      rchk("done", 8'h9C, {2'h2, s[0], 1'b1, chan});
      rchk("lo", 8'h9E, s[0] ? r[7:0] : {r[3:0], 4'h0});
      rchk("hi", 8'h9F, s[0] ? {4'h0, r[11:8]} : r[11:4]);
      rchk("flag", 8'h9D, {5'h10, s[0], s[1:0]});
      chk("irq", 16'(s != 0), 16'(irq));
      rchk("status", 8'hA0, 8'h01);
      if (s[1])
         ack();
      else
         wreg(8'h9D, {5'h00, s[0], s[1:0]});
      wreg(8'hA2, 8'h01);
      rchk("clr", 8'hA0, 8'h00);
      chk("cirq", 16'h0, 16'(cirq));
      chk("irq", 16'h0, 16'(irq));
   end
   $display("test conversions done");
   for (int t = 0; t < 8; t++)
   begin
      wreg(8'h9D, {2'h0, 3'(t), 3'h0});
      wreg(8'h9C, 8'h80);
      tmr <= (t > 0 && t < 6) ? 5'(1 << (t - 1)) : 5'h1F;
      wait_irq(t > 0 && t < 6);
      tmr <= 5'h00;
      ack();
   end
   $display("test triggers done");
   wreg(8'h9D, 8'h08);
   wreg(8'h9C, 8'h00);
   rchk("off", 8'h9C, 8'h00);
   @(posedge clk);
   tmr <= 5'h01;
   wait_irq(1'b0);
   tmr <= 5'h00;
   $display("test disabled done");
   // Register writes must be ignored while the clock enable is low
   ce <= 1'b0;
   wreg(8'h9C, 8'h0F);
   ce <= 1'b1;
   rchk("frozen", 8'h9C, 8'h00);
   $display("test clock enable done");
   wreg(8'h9D, 8'h00);
   wreg(8'h9C, 8'hC0);
   wreg(8'h9C, 8'hC0);
   wait_irq(1'b1);
   rchk("lost", 8'hA0, 8'h03);
   ack();
   stop_mode <= 1'b1;
   wreg(8'h9C, 8'hC0);
   wait_irq(1'b0);
   chk("pwr", 16'h0, 16'(pwr));
   rchk("stop", 8'h9C, 8'h80);
   $display("test stop done");
   finish_test();
end
endmodule
bind adsq_top adsq_top_props chk_i (.clk(clk), .rst_n(rst_n), .ce(ce),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .stop_mode(stop_mode),
   .irq_ack(irq_ack), .input_channel_select(input_channel_select),
   .reference_source_select(reference_source_select),
   .module_power_enable(module_power_enable), .sar_sample(sar_sample),
   .sar_step(sar_step), .conv_irq(conv_irq));
